// ### test/bmcs_master_sva.sv
// bmcs_master_sva: concurrent checks on the ports of the bus-master cycle block.
// assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/1ps
module bmcs_master_sva
    import bmcs_pkg::*;
#(
    parameter int unsigned POC_CYCLES = POC_CYC
) (
    // clock and reset
    input wire logic              mclk_i,
    input wire logic              rst_i,
    // watched ports
    input wire logic              ack_o,
    input wire logic [ADDR_W-1:0] bus_addr_o,
    input wire logic              s_out_o,
    input wire logic              s_inp_o,
    input wire logic              s_memr_o,
    input wire logic              s_inta_o,
    input wire logic              s_mreq_n_o,
    input wire logic              s_rfsh_n_o,
    input wire logic              s_wo_n_o,
    input wire logic              p_sync_o,
    input wire logic              p_wr_n_o,
    input wire logic              mwrt_o,
    input wire logic              bus_clk_o,
    input wire logic              reset_n_i,
    input wire logic              poc_n_oe_o
);
////////////////////////////////////////////////////////////////////////////////
// counts how long power-on-clear has been pulled; cleared by rst_i so it never starts unknown
logic [POC_CNT_W-1:0] poc_cnt_r;
always_ff @(posedge mclk_i) begin
    if (rst_i || !poc_n_oe_o) begin
        poc_cnt_r <= '0;
    end else if (!(&poc_cnt_r)) begin
        poc_cnt_r <= poc_cnt_r + 1'b1;
    end
end
////////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge mclk_i); endclocking
default disable iff (rst_i);
a_mwrt_term: assert property (mwrt_o == (!p_wr_n_o && !s_out_o))
    else $error("memory write strobe differs from write and not output");
a_write_flags_wo: assert property (!p_wr_n_o |-> !s_wo_n_o)
    else $error("write strobe without write status");
a_inta_no_memr: assert property (s_inta_o |-> !s_memr_o)
    else $error("memory read status on interrupt acknowledge");
a_io_dir_excl: assert property (!(s_inp_o && s_out_o))
    else $error("input and output status together");
a_rfsh_addr: assert property (!s_rfsh_n_o |-> !s_mreq_n_o && bus_addr_o[15:7] == 9'h000)
    else $error("refresh without memory request or with high address bits");
a_sync_status: assert property (p_sync_o |=> $stable({s_out_o, s_inp_o, s_memr_o, s_mreq_n_o, bus_addr_o}))
    else $error("status moved during sync");
a_sync_width: assert property ($rose(p_sync_o) |-> p_sync_o[*5] ##1 !p_sync_o)
    else $error("sync pulse width wrong");
a_ack_bound: assert property ($rose(p_sync_o) && (s_memr_o || s_inp_o || !s_wo_n_o) |-> ##[9:600] ack_o)
    else $error("cycle end outside bound");
a_clk_period: assert property ($rose(bus_clk_o) |-> bus_clk_o[*3] ##1 !bus_clk_o[*2] ##1 bus_clk_o)
    else $error("bus clock period wrong");
a_poc_min: assert property ($fell(poc_n_oe_o) |-> poc_cnt_r >= POC_CYCLES - 1)
    else $error("power-on-clear released early");
a_reset_poc: assert property (!reset_n_i |-> ##[1:6] poc_n_oe_o)
    else $error("bus reset did not pull power-on-clear");
endmodule // bmcs_master_sva

bind bmcs_master bmcs_master_sva #(.POC_CYCLES(POC_CYCLES)) bmcs_master_sva_inst (
    .mclk_i(mclk_i), .rst_i(rst_i), .ack_o(ack_o), .bus_addr_o(bus_addr_o),
    .s_out_o(s_out_o), .s_inp_o(s_inp_o), .s_memr_o(s_memr_o), .s_inta_o(s_inta_o),
    .s_mreq_n_o(s_mreq_n_o), .s_rfsh_n_o(s_rfsh_n_o), .s_wo_n_o(s_wo_n_o),
    .p_sync_o(p_sync_o), .p_wr_n_o(p_wr_n_o), .mwrt_o(mwrt_o), .bus_clk_o(bus_clk_o),
    .reset_n_i(reset_n_i), .poc_n_oe_o(poc_n_oe_o));

// ### test/bmcs_master_tb.sv
// bmcs_master_tb: self-checking bench for the bus-master cycle block.
// assumes the slave model answers reads and the checker is bound in.
`timescale 1ns/1ps
module bmcs_master_tb;
import bmcs_pkg::*;
localparam logic [7:0] STAT [8] = '{8'h13, 8'h02, 8'h27, 8'h46, 8'h93, 8'haf, 8'h01, 8'h00};
logic mclk_i = 0, rst_i = 1, req_i = 0, xrdy_i = 1, hold_n_i = 1, int_n_i = 1;
logic reset_n_i = 1, slow = 0, sync_q = 0, rdy_i;
logic [2:0]  kind_i = 3'h0;
logic [15:0] addr_i = 16'h0000, bus_addr_o;
logic [7:0]  wdata_i = 8'h00, rdata_o, bus_dout_o, bus_din_i;
logic ack_o, int_pend_o, halted_o, reset_busy_o, s_m1_o, s_out_o, s_inp_o, s_memr_o;
logic s_hlta_o, s_inta_o, s_mreq_n_o, s_rfsh_n_o, s_wo_n_o, p_sync_o, p_wr_n_o, p_dbin_o;
logic p_hlda_o, mwrt_o, bus_clk_o, poc_n_o, poc_n_oe_o;
logic [32:0] st_q [$];
logic [8:0]  rd_q [$];
logic [32:0] se;
logic [8:0]  re;
int failures = 0, comparisons = 0, cyc = 0;
////////////////////////////////////////////////////////////////////////////////
bmcs_master #(.POC_CYCLES(50)) bmcs_master_inst (.mclk_i, .rst_i, .req_i, .kind_i, .addr_i,
    .wdata_i, .ack_o, .rdata_o, .int_pend_o, .halted_o, .reset_busy_o, .bus_addr_o,
    .bus_dout_o, .bus_din_i, .s_m1_o, .s_out_o, .s_inp_o, .s_memr_o, .s_hlta_o, .s_inta_o,
    .s_mreq_n_o, .s_rfsh_n_o, .s_wo_n_o, .p_sync_o, .p_wr_n_o, .p_dbin_o, .p_hlda_o,
    .mwrt_o, .bus_clk_o, .rdy_i, .xrdy_i, .hold_n_i, .int_n_i, .reset_n_i, .poc_n_o,
    .poc_n_oe_o);
bmcs_slave bmcs_slave_inst (.mclk_i, .addr_i(bus_addr_o), .dbin_i(p_dbin_o), .slow_i(slow),
    .phantom_n_i(1'b1), .din_o(bus_din_i), .rdy_o(rdy_i));
initial begin
    forever #50 mclk_i = ~mclk_i;
end
////////////////////////////////////////////////////////////////////////////////
task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
        failures++;
        $display("mismatch %s expected %h seen %h", what, exp, got);
    end
endtask
task automatic end_sim();
    if (failures == 0 && comparisons > 0) begin
        $display("No errors found");
    end else begin
        $display("Errors were found");
    end
    $finish;
endtask
task automatic wait_on(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 400) begin
        @(posedge mclk_i);
        n++;
    end
    if (s !== v) failures++;
endtask
// one whole bus cycle; expectations are queued before the request goes out
task automatic cycle(input logic [2:0] k, input logic [15:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge mclk_i);
    if (k != KIND_HALT) begin
        st_q.push_back({k == KIND_MEM_WR || k == KIND_IO_WR, STAT[k],
                        k == KIND_RFSH ? {9'h000, a[6:0]} : a, d});
    end
    rd_q.push_back({k inside {KIND_MEM_RD, KIND_IO_RD, KIND_FETCH, KIND_INTA},
                    a[7:0] ^ a[15:8] ^ 8'h5a});
    req_i <= 1'b1;
    kind_i <= k;
    addr_i <= a;
    wdata_i <= d;
    do begin
        @(posedge mclk_i);
        n++;
    end while (ack_o !== 1'b1 && n < 2000);
    if (ack_o !== 1'b1) failures++;
    req_i <= 1'b0;
endtask
////////////////////////////////////////////////////////////////////////////////
always @(posedge mclk_i) begin
    cyc++;
    xrdy_i <= slow ? 1'($urandom_range(1, 0)) : 1'b1;
    if (cyc == 40000) begin
        failures++;
        end_sim();
    end
end
// result watcher: status at the sync pulse, read byte at the end of the cycle
always @(posedge mclk_i) begin
    sync_q <= p_sync_o;
    if (p_sync_o && !sync_q && st_q.size() > 0) begin
        se = st_q.pop_front();
        check("status", {24'h00_0000, se[31:24]}, {24'h00_0000, s_m1_o, s_out_o, s_inp_o,
              s_memr_o, s_inta_o, s_mreq_n_o, s_rfsh_n_o, s_wo_n_o});
        check("address", {16'h0000, se[23:8]}, {16'h0000, bus_addr_o});
        if (se[32]) check("data out", {24'h00_0000, se[7:0]}, {24'h00_0000, bus_dout_o});
    end
    if (ack_o === 1'b1 && rd_q.size() > 0) begin
        re = rd_q.pop_front();
        if (re[8]) check("read data", {24'h00_0000, re[7:0]}, {24'h00_0000, rdata_o});
    end
end
////////////////////////////////////////////////////////////////////////////////
initial begin
    void'($urandom(32'h183d_4be8));
    repeat (10) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    @(posedge mclk_i);
    check("reset busy", 32'h0000_0001, {31'h0, reset_busy_o});
    check("poc level", 32'h0000_0000, {31'h0, poc_n_o});
    wait_on(reset_busy_o, 1'b0);
    for (int k = 0; k < 7; k++) begin
        cycle(3'(k), 16'h8001 + 16'(k) * 16'h1111, 8'ha5 ^ 8'(k));
    end
    slow <= 1'b1;
    repeat (40) cycle(3'($urandom_range(6, 0)), 16'($urandom), 8'($urandom));
    slow <= 1'b0;
    int_n_i <= 1'b0;
    wait_on(int_pend_o, 1'b1);
    check("int pending", 32'h0000_0001, {31'h0, int_pend_o});
    int_n_i <= 1'b1;
    // let the released request pass the synchroniser, else its set beats the clear
    repeat (6) @(posedge mclk_i);
    cycle(KIND_INTA, 16'h00ff, 8'h00);
    check("int cleared", 32'h0000_0000, {31'h0, int_pend_o});
    cycle(KIND_HALT, 16'h0000, 8'h00);
    repeat (3) @(posedge mclk_i);
    check("halt status", 32'h0000_0003, {30'h0, s_hlta_o, halted_o});
    hold_n_i <= 1'b0;
    wait_on(p_hlda_o, 1'b1);
    check("hold grant", 32'h0000_0001, {31'h0, p_hlda_o});
    hold_n_i <= 1'b1;
    wait_on(p_hlda_o, 1'b0);
    check("hold release", 32'h0000_0000, {31'h0, p_hlda_o});
    cycle(KIND_MEM_WR, 16'hffff, 8'h80);
    reset_n_i <= 1'b0;
    repeat (20) @(posedge mclk_i);
    check("bus reset busy", 32'h0000_0001, {31'h0, reset_busy_o});
    reset_n_i <= 1'b1;
    wait_on(reset_busy_o, 1'b0);
    cycle(KIND_MEM_RD, 16'h0001, 8'h00);
    repeat (5) @(posedge mclk_i);
    check("pending status", 32'h0000_0000, 32'(st_q.size()));
    check("pending reads", 32'h0000_0000, 32'(rd_q.size()));
    end_sim();
end
endmodule // bmcs_master_tb

// ### test/bmcs_slave.sv
// bmcs_slave: behavioural slave board answering read strobes on the backplane.
// assumes data-in is sampled by the master well after the strobe rises.
`timescale 1ns/1ps
module bmcs_slave (
    // clock
    input  wire logic        mclk_i,
    // bus side
    input  wire logic [15:0] addr_i,
    input  wire logic        dbin_i,
    input  wire logic        slow_i,
    input  wire logic        phantom_n_i,
    output logic      [7:0]  din_o,
    output logic             rdy_o
);
initial begin
    din_o = 8'h00;
    rdy_o = 1'b1;
end
// outside a read the lines toggle, so a stale byte can never look valid
always @(posedge mclk_i) begin
    din_o <= (dbin_i && phantom_n_i) ? (addr_i[7:0] ^ addr_i[15:8] ^ 8'h5a) : ~din_o;
    rdy_o <= slow_i ? 1'($urandom_range(1, 0)) : 1'b1;
end
endmodule // bmcs_slave

// ### verilog/bmcs_master.sv
// bmcs_master: bus-master cycle logic of a processor card on a parallel
// backplane: address, data paths, status, strobes, ready, hold, interrupt
// and the reset chain. assumes a core that requests one cycle at a time
// and off-chip drivers that turn the _oe outputs into open-collector pulls.
`timescale 1ns/1ps
// Contract
// R1 - sM1 high only on op-code fetch cycles; the code also raises it on interrupt-acknowledge cycles.
// R2 - sOUT high on I/O write cycles.
// R3 - sINP high on I/O read cycles.
// R4 - sMEMR high on memory reads, not interrupt-acknowledge fetches.
// R5 - sHLTA high once a halt instruction executed.
// R6 - free-running 2 MHz bus clock, 40 to 60 percent duty.
// R7 - sMREQ low on every memory read, write or refresh cycle.
// R8 - sRFSH low when low address lines carry a refresh address.
// R9 - memory boards go quiet while PHANTOM is held low.
// R10 - memory write equals write strobe active and sOUT inactive.
// R11 - bus ready only when both ready inputs are true.
// R12 - INT low requests service; sINTA marks following input cycles.
// R13 - HOLD low asks for the bus; pHLDA answers before hand-over.
// R14 - bus reset resets masters and activates power-on-clear.
// R15 - power-on-clear stays low at least 10 ms once driven low.
// R16 - pSYNC pulses at the start of each bus cycle.
// R17 - pWR low only while write data valid on data-out.
// R18 - pDBIN high requests read data; slave drives data-in.
// R19 - sWO low on every master-to-slave transfer.
// R20 - 16-bit active-high address, bit 0 least significant.
// R21 - separate 8-bit data-out and data-in paths.
// R22 - asterisk signals active low; open-collector lines only pulled low.
// R23 - status held stable from pSYNC to end of cycle.
module bmcs_master
    import bmcs_pkg::*;
#(
    parameter int unsigned POC_CYCLES = POC_CYC
) (
    // clock and reset
    input  wire logic              mclk_i,
    input  wire logic              rst_i,
    // core request side
    input  wire logic              req_i,
    input  wire logic [2:0]        kind_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    output logic                   ack_o,
    output logic [DATA_W-1:0]      rdata_o,
    output logic                   int_pend_o,
    output logic                   halted_o,
    output logic                   reset_busy_o,
    // bus address and data
    output logic [ADDR_W-1:0]      bus_addr_o,
    output logic [DATA_W-1:0]      bus_dout_o,
    input  wire logic [DATA_W-1:0] bus_din_i,
    // bus status
    output logic                   s_m1_o,
    output logic                   s_out_o,
    output logic                   s_inp_o,
    output logic                   s_memr_o,
    output logic                   s_hlta_o,
    output logic                   s_inta_o,
    output logic                   s_mreq_n_o,
    output logic                   s_rfsh_n_o,
    output logic                   s_wo_n_o,
    // bus control strobes
    output logic                   p_sync_o,
    output logic                   p_wr_n_o,
    output logic                   p_dbin_o,
    output logic                   p_hlda_o,
    output logic                   mwrt_o,
    output logic                   bus_clk_o,
    // ready, hold and interrupt pins
    input  wire logic              rdy_i,
    input  wire logic              xrdy_i,
    input  wire logic              hold_n_i,
    input  wire logic              int_n_i,
    // reset chain, open collector: oe high pulls the line low
    input  wire logic              reset_n_i,
    output logic                   poc_n_o,
    output logic                   poc_n_oe_o
);
    //////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic rdy_s;
    logic xrdy_s;
    logic hold_n_s;
    logic int_n_s;
    logic reset_n_s;

    bmcs_sync3 u_rdy (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .pin_i     (rdy_i),
        .rst_val_i (1'b0),
        .level_o   (rdy_s)
    );

    bmcs_sync3 u_xrdy (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .pin_i     (xrdy_i),
        .rst_val_i (1'b0),
        .level_o   (xrdy_s)
    );

    bmcs_sync3 u_hold (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .pin_i     (hold_n_i),
        .rst_val_i (1'b1),
        .level_o   (hold_n_s)
    );

    bmcs_sync3 u_int (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .pin_i     (int_n_i),
        .rst_val_i (1'b1),
        .level_o   (int_n_s)
    );

    bmcs_sync3 u_reset (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .pin_i     (reset_n_i),
        .rst_val_i (1'b1),
        .level_o   (reset_n_s)
    );

    //////////////////////////////////////////////////////////////////////
    // free-running bus clock; five system cycles cannot split evenly, so
    // the high phase takes three of them (60 percent, inside the band)
    logic [DIV_W-1:0] div_r;
    logic             bus_clk_r;
    wire              div_wrap = (div_r == DIV_W'(BUS_PER_CYC - 1));
    wire [DIV_W-1:0]  div_nxt  = div_wrap ? '0 : div_r + 1'b1;
    wire              clk_high = (div_nxt < DIV_W'(BUS_HIGH_CYC));

    // reset level matches count zero, so no short first pulse follows reset
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            div_r     <= '0;
            bus_clk_r <= 1'b1;
        end else begin
            div_r     <= div_nxt;
            bus_clk_r <= clk_high;                                       // R6
        end
    end

    //////////////////////////////////////////////////////////////////////
    // reset chain: bus reset or local reset starts power-on-clear
    logic [POC_CNT_W-1:0] poc_cnt_r;
    logic                 poc_act_r;
    wire                  poc_start = ~reset_n_s;                        // R14
    wire                  poc_run   = poc_cnt_r != POC_CNT_W'(POC_CYCLES - 1);

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            poc_cnt_r <= '0;
            poc_act_r <= 1'b1;
        end else if (poc_start) begin
            poc_cnt_r <= '0;
            poc_act_r <= 1'b1;                                           // R14
        end else if (poc_act_r && poc_run) begin
            poc_cnt_r <= poc_cnt_r + 1'b1;                               // R15
        end else begin
            poc_act_r <= 1'b0;                                           // R15
        end
    end

    // masters held in reset while clear is active; the open-collector pin
    // only ever pulls low, so the data bit is fixed at zero
    wire bus_rst = rst_i | poc_act_r;                                     // R14

    //////////////////////////////////////////////////////////////////////
    // cycle decode
    wire k_fetch = (kind_i == KIND_FETCH);
    wire k_inta  = (kind_i == KIND_INTA);
    wire k_memrd = (kind_i == KIND_MEM_RD);
    wire k_memwr = (kind_i == KIND_MEM_WR);
    wire k_iord  = (kind_i == KIND_IO_RD);
    wire k_iowr  = (kind_i == KIND_IO_WR);
    wire k_rfsh  = (kind_i == KIND_RFSH);
    wire k_halt  = (kind_i == KIND_HALT);
    wire k_read  = k_fetch | k_memrd | k_iord | k_inta;
    wire k_write = k_memwr | k_iowr;
    wire ready   = rdy_s & xrdy_s;                                       // R11
    wire hold_rq = ~hold_n_s;
    wire bclk_rise = div_wrap & ~bus_clk_r;

    //////////////////////////////////////////////////////////////////////
    // cycle state machine, steps on the rising bus-clock edge
    bmcs_state_e state_r;
    bmcs_state_e state_nxt;
    logic        is_write_r;
    logic        is_read_r;
    logic        is_out_r;
    logic        int_pend_r;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            BMCS_IDLE: begin
                if (hold_rq) begin
                    state_nxt = BMCS_HOLD;                               // R13
                end else if (req_i && k_halt) begin
                    state_nxt = BMCS_HALT;
                end else if (req_i) begin
                    state_nxt = BMCS_SYNC;
                end
            end
            BMCS_SYNC: state_nxt = BMCS_XFER;
            BMCS_XFER: begin
                if (ready) begin
                    state_nxt = BMCS_DONE;
                end
            end
            BMCS_DONE: state_nxt = BMCS_IDLE;
            BMCS_HOLD: begin
                if (!hold_rq) begin
                    state_nxt = BMCS_IDLE;
                end
            end
            BMCS_HALT: begin
                // an interrupt or hold wakes the halted master
                if (!int_n_s || hold_rq) begin
                    state_nxt = BMCS_IDLE;
                end
            end
            default: state_nxt = BMCS_IDLE;
        endcase
    end

    wire start_cyc = bclk_rise && (state_r == BMCS_IDLE) && (state_nxt == BMCS_SYNC);
    wire in_xfer   = (state_r == BMCS_XFER);
    wire finish    = bclk_rise && in_xfer && ready;

    always_ff @(posedge mclk_i) begin
        if (bus_rst) begin
            state_r <= BMCS_IDLE;
        end else if (bclk_rise) begin
            state_r <= state_nxt;
        end
    end

    // interrupt pending: set wins over the clear by an acknowledge cycle
    always_ff @(posedge mclk_i) begin
        if (bus_rst) begin
            int_pend_r <= 1'b0;
        end else if (!int_n_s) begin
            int_pend_r <= 1'b1;                                          // R12
        end else if (start_cyc && k_inta) begin
            int_pend_r <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // status latch: loaded at cycle start, held to cycle end
    always_ff @(posedge mclk_i) begin
        if (bus_rst) begin
            bus_addr_o <= '0;
            bus_dout_o <= '0;
            s_m1_o     <= 1'b0;
            s_out_o    <= 1'b0;
            s_inp_o    <= 1'b0;
            s_memr_o   <= 1'b0;
            s_inta_o   <= 1'b0;
            s_mreq_n_o <= 1'b1;
            s_rfsh_n_o <= 1'b1;
            s_wo_n_o   <= 1'b1;
            is_write_r <= 1'b0;
            is_read_r  <= 1'b0;
            is_out_r   <= 1'b0;
        end else if (start_cyc) begin                                    // R23
            bus_addr_o <= k_rfsh ? {{(ADDR_W-RFSH_W){1'b0}},
                                    addr_i[RFSH_W-1:0]} : addr_i;        // R20 R8
            bus_dout_o <= k_write ? wdata_i : bus_dout_o;                // R21
            s_m1_o     <= k_fetch | k_inta;                              // R1
            s_out_o    <= k_iowr;                                        // R2
            s_inp_o    <= k_iord | k_inta;                               // R3 R12
            s_memr_o   <= k_fetch | k_memrd;                             // R4
            s_inta_o   <= k_inta;                                        // R12
            s_mreq_n_o <= ~(k_fetch | k_memrd | k_memwr | k_rfsh);       // R7
            s_rfsh_n_o <= ~k_rfsh;                                       // R8
            s_wo_n_o   <= ~k_write;                                      // R19
            is_write_r <= k_write;
            is_read_r  <= k_read;
            is_out_r   <= k_iowr;
        end else if (bclk_rise && state_r == BMCS_DONE) begin
            s_m1_o     <= 1'b0;
            s_out_o    <= 1'b0;
            s_inp_o    <= 1'b0;
            s_memr_o   <= 1'b0;
            s_inta_o   <= 1'b0;
            s_mreq_n_o <= 1'b1;
            s_rfsh_n_o <= 1'b1;
            s_wo_n_o   <= 1'b1;
            is_write_r <= 1'b0;
            is_read_r  <= 1'b0;
            is_out_r   <= 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // strobes; data-out is already stable when the write strobe falls
    wire wr_act = in_xfer & is_write_r;                                  // R17
    wire rd_act = in_xfer & is_read_r;                                   // R18

    always_ff @(posedge mclk_i) begin
        if (bus_rst) begin
            p_sync_o    <= 1'b0;
            p_wr_n_o    <= 1'b1;
            p_dbin_o    <= 1'b0;
            mwrt_o      <= 1'b0;
            p_hlda_o    <= 1'b0;
            s_hlta_o    <= 1'b0;
            ack_o       <= 1'b0;
            rdata_o     <= '0;
        end else begin
            p_sync_o    <= (state_r == BMCS_SYNC);                       // R16
            p_wr_n_o    <= ~wr_act;                                      // R17
            p_dbin_o    <= rd_act;                                       // R18
            // same registered term as the write strobe, so it tracks it
            mwrt_o      <= wr_act & ~is_out_r;                           // R10
            p_hlda_o    <= (state_r == BMCS_HOLD);                       // R13
            s_hlta_o    <= (state_r == BMCS_HALT);                       // R5
            ack_o       <= finish | (bclk_rise && state_r == BMCS_IDLE
                                     && req_i && k_halt && !hold_rq);
            rdata_o     <= (finish && is_read_r) ? bus_din_i : rdata_o;  // R18 R21
        end
    end

    //////////////////////////////////////////////////////////////////////
    // misc outputs
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            bus_clk_o    <= 1'b0;
            poc_n_o      <= 1'b0;
            poc_n_oe_o   <= 1'b1;
            int_pend_o   <= 1'b0;
            halted_o     <= 1'b0;
            reset_busy_o <= 1'b1;
        end else begin
            bus_clk_o    <= bus_clk_r;                                   // R6
            poc_n_o      <= 1'b0;                                        // R22
            poc_n_oe_o   <= poc_act_r;                                   // R15 R22
            int_pend_o   <= int_pend_r;
            halted_o     <= (state_r == BMCS_HALT);
            reset_busy_o <= poc_act_r;
        end
    end
endmodule // bmcs_master

// ### verilog/bmcs_pkg.sv
// bmcs_pkg: constants for the backplane bus-master cycle block.
// assumes a 10 MHz system clock on mclk_i.
package bmcs_pkg;
    localparam int unsigned CLK_HZ        = 10000000;
    localparam int unsigned BUS_CLK_HZ    = 2000000;
    // bus clock period and its high phase in system cycles
    localparam int unsigned BUS_PER_CYC   = CLK_HZ / BUS_CLK_HZ;
    localparam int unsigned BUS_HIGH_CYC  = 3;
    localparam int unsigned POC_TIME_MS   = 10;
    // least time in whole cycles; the division truncates, nothing is added
    localparam int unsigned POC_CYC       = (CLK_HZ / 1000 * POC_TIME_MS + 0) ;
    localparam int unsigned ADDR_W        = 16;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned RFSH_W        = 7;
    localparam int unsigned POC_CNT_W     = 24;
    localparam int unsigned DIV_W         = 4;

    // cycle kinds requested by the core
    localparam logic [2:0]  KIND_MEM_RD   = 3'h0;
    localparam logic [2:0]  KIND_MEM_WR   = 3'h1;
    localparam logic [2:0]  KIND_IO_RD    = 3'h2;
    localparam logic [2:0]  KIND_IO_WR    = 3'h3;
    localparam logic [2:0]  KIND_FETCH    = 3'h4;
    localparam logic [2:0]  KIND_INTA     = 3'h5;
    localparam logic [2:0]  KIND_RFSH     = 3'h6;
    localparam logic [2:0]  KIND_HALT     = 3'h7;

    typedef enum logic [5:0] {
        BMCS_IDLE  = 6'b00_0001,
        BMCS_SYNC  = 6'b00_0010,
        BMCS_XFER  = 6'b00_0100,
        BMCS_DONE  = 6'b00_1000,
        BMCS_HOLD  = 6'b01_0000,
        BMCS_HALT  = 6'b10_0000
    } bmcs_state_e;
endpackage

// ### verilog/bmcs_sync3.sv
// bmcs_sync3: three-flop synchroniser for one pin, change taken when
// stages two and three agree. assumes input is asynchronous to mclk_i.
`timescale 1ns/1ps
module bmcs_sync3 (
    // clock and reset
    input  wire logic mclk_i,
    input  wire logic rst_i,
    // pin and result
    input  wire logic pin_i,
    input  wire logic rst_val_i,
    output logic      level_o
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    always_ff @(posedge mclk_i) begin
        s1_r <= pin_i;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end

    // reset value comes from a tie-off, held in a clocked process
    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            level_o <= rst_val_i;
        end else if (s2_r == s3_r) begin
            level_o <= s3_r;
        end
    end
endmodule // bmcs_sync3
